// ### verilog/buf_ctrl_regs.svh
// Behaviour
// [R1] scratch word, reset zero, read 28 write A8
// [R2] key F6H clears registers, buffer RAM kept
// [R3] restart register write-only at code A9
// [R4] one iso size for both areas, 2A/AA
// [R5] software keeps ack plus twice iso within 4096
// [R6] ack area size register, 2B/AB, reset zero
// [R7] status read-only at 2C, bits 15:6 zero
// [R8] bit 5 set when ack area consumed
// [R9] bits 4,3 set when iso areas consumed
// [R10] bits 2,1,0 show ack/iso areas full
// [R11] flags update on pointer reaching byte count
// [R12] non-key restart writes change nothing
// [R13] writes to status word are ignored
`ifndef BUF_CTRL_REGS_SVH
`define BUF_CTRL_REGS_SVH

`define RD_SCRATCH 8'h28
`define WR_SCRATCH 8'hA8
`define WR_RESTART 8'hA9
`define RD_ISO_SIZE 8'h2A
`define WR_ISO_SIZE 8'hAA
`define RD_ACK_SIZE 8'h2B
`define WR_ACK_SIZE 8'hAB
`define RD_FILL_STATE 8'h2C
`define WR_FILL_STATE 8'hAC
`define RESTART_KEY 16'h00F6
`define REG_RESET 16'h0000
`define STATUS_RESET 6'h00
`define STATUS_DONE_LSB 3
`define STATUS_FULL_LSB 0
`define BUF_RAM_BYTES 16'h1000
`define PTR_STEP 16'h0002

`endif

// ### verilog/buf_ctrl_pkg.sv
`default_nettype none
package buf_ctrl_pkg;

  // area index matches bit order within the full and done groups
  typedef enum logic [1:0] {
    first_iso_area,
    second_iso_area,
    acknowledged_list_area
  } area_t;

  typedef enum logic {
    trk_idle,
    trk_run
  } trk_state_t;

  function automatic logic [2:0] area_onehot(input area_t a);
    logic [2:0] m;
    m = 3'h0;
    case (a)
      first_iso_area: m = 3'h1;
      second_iso_area: m = 3'h2;
      acknowledged_list_area: m = 3'h4;
      default: m = 3'h0;
    endcase
    return m;
  endfunction : area_onehot

endpackage : buf_ctrl_pkg
`default_nettype wire

// ### verilog/buf_xfer_tracker.sv
`include "buf_ctrl_regs.svh"
`default_nettype none
module buf_xfer_tracker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic soft_clr,
  input wire logic xfer_start,
  input wire logic [15:0] xfer_count,
  input wire buf_ctrl_pkg::area_t xfer_area,
  input wire logic xfer_write,
  input wire logic word_strobe,
  output logic eot_q,
  output buf_ctrl_pkg::area_t eot_area_q,
  output logic eot_write_q
);
  import buf_ctrl_pkg::*;

  trk_state_t state_q;
  logic [15:0] ptr_q;
  logic [15:0] count_q;
  logic [16:0] ptr_next;
  logic reached;

  assign ptr_next = {1'b0, ptr_q} + {1'b0, `PTR_STEP};
  assign reached = ptr_next >= {1'b0, count_q};

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= trk_idle;
      ptr_q <= 16'h0000;
      count_q <= 16'h0000;
      eot_area_q <= first_iso_area;
      eot_write_q <= 1'b0;
    end else if (soft_clr) begin
      state_q <= trk_idle;
      ptr_q <= 16'h0000;
      count_q <= 16'h0000;
    end else begin
      case (state_q)
        trk_idle: begin
          if (xfer_start) begin
            state_q <= trk_run;
            ptr_q <= 16'h0000;
            count_q <= xfer_count;
            eot_area_q <= xfer_area;
            eot_write_q <= xfer_write;
          end
        end
        trk_run: begin
          // pointer steps two bytes per data word
          if (word_strobe) begin
            ptr_q <= ptr_next[15:0]; // [R11]
            if (reached) begin
              state_q <= trk_idle;
            end
          end
        end
        default: state_q <= trk_idle;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      eot_q <= 1'b0;
    end else begin
      eot_q <= !soft_clr && state_q == trk_run && word_strobe
        && reached; // [R11]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_eot_on_reach: assert property (
    !soft_clr && state_q == trk_run && word_strobe && reached
    |=> eot_q && state_q == trk_idle) // [R11]
    else $error("end of transfer missing at byte count");

  a_no_early_eot: assert property (
    state_q == trk_run && !(word_strobe && reached) |=> !eot_q) // [R11]
    else $error("end of transfer before byte count");

endmodule : buf_xfer_tracker
`default_nettype wire

// ### verilog/buf_ctrl_regs.sv
`include "buf_ctrl_regs.svh"
`default_nettype none
module buf_ctrl_regs (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  input wire logic xfer_start,
  input wire logic [15:0] xfer_count,
  input wire buf_ctrl_pkg::area_t xfer_area,
  input wire logic xfer_write,
  input wire logic word_strobe,
  input wire logic [2:0] host_consumed,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic [15:0] iso_size_q,
  output logic [15:0] ack_size_q,
  output logic restart_q
);
  import buf_ctrl_pkg::*;

  logic [15:0] scratch_q;
  logic [2:0] full_q;
  logic [2:0] done_q;
  logic [5:0] status;
  logic soft_clr;
  logic transfer_finished_event;
  area_t eot_area;
  logic eot_write;
  logic [2:0] eot_fill;
  logic [2:0] eot_back;

  function automatic logic is_wr(input logic v, input logic [7:0] c,
                                 input logic [7:0] code);
    return v && c == code;
  endfunction : is_wr

  // only the full key restarts; anything else is dropped
  assign soft_clr = is_wr(cmd_valid, cmd_code, `WR_RESTART)
    && cmd_wdata == `RESTART_KEY; // [R2] [R3] [R12]
  assign status = {done_q, full_q};

  //////////////////////////////////////////////////////////////////////////
  buf_xfer_tracker u_tracker (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .soft_clr(soft_clr),
    .xfer_start(xfer_start),
    .xfer_count(xfer_count),
    .xfer_area(xfer_area),
    .xfer_write(xfer_write),
    .word_strobe(word_strobe),
    .eot_q(transfer_finished_event),
    .eot_area_q(eot_area),
    .eot_write_q(eot_write)
  );

  assign eot_fill = (transfer_finished_event && eot_write) ? area_onehot(eot_area) : 3'h0;
  assign eot_back = (transfer_finished_event && !eot_write) ? area_onehot(eot_area) : 3'h0;

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      scratch_q <= `REG_RESET;
    end else if (soft_clr) begin
      scratch_q <= `REG_RESET; // [R2]
    end else if (is_wr(cmd_valid, cmd_code, `WR_SCRATCH)) begin
      scratch_q <= cmd_wdata; // [R1]
    end
  end

  // no range check: keeping the map within the RAM is up to software
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      iso_size_q <= `REG_RESET;
      ack_size_q <= `REG_RESET;
    end else if (soft_clr) begin
      iso_size_q <= `REG_RESET; // [R2]
      ack_size_q <= `REG_RESET;
    end else begin
      if (is_wr(cmd_valid, cmd_code, `WR_ISO_SIZE)) begin
        iso_size_q <= cmd_wdata; // [R4]
      end
      if (is_wr(cmd_valid, cmd_code, `WR_ACK_SIZE)) begin
        ack_size_q <= cmd_wdata; // [R6]
      end
    end
  end

  // set terms are or-ed last so an event beats a clear in the same cycle;
  // of the command codes only the restart key write reaches these flops
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      full_q <= 3'h0;
      done_q <= 3'h0;
    end else if (soft_clr) begin
      full_q <= 3'h0; // [R2]
      done_q <= 3'h0;
    end else begin
      full_q <= (full_q & ~host_consumed) | eot_fill; // [R10] [R11] [R13]
      done_q <= (done_q & ~eot_fill & ~eot_back)
        | host_consumed; // [R8] [R9]
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= soft_clr; // [R2]
    end
  end

  //////////////////////////////////////////////////////////////////////////
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= cmd_valid && !cmd_code[7];
      if (cmd_valid && !cmd_code[7]) begin
        case (cmd_code)
          `RD_SCRATCH: rd_data <= scratch_q; // [R1]
          `RD_ISO_SIZE: rd_data <= iso_size_q; // [R4]
          `RD_ACK_SIZE: rd_data <= ack_size_q; // [R6]
          `RD_FILL_STATE: rd_data <= {10'h000, status}; // [R7]
          default: rd_data <= 16'h0000;
        endcase
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  sequence key_write;
    cmd_valid && cmd_code == `WR_RESTART && cmd_wdata == `RESTART_KEY;
  endsequence

  sequence all_cleared;
    scratch_q == 16'h0000 && iso_size_q == 16'h0000
      && ack_size_q == 16'h0000 && status == 6'h00 && restart_q;
  endsequence

  a_scratch_read: assert property (
    cmd_valid && cmd_code == `RD_SCRATCH
    |=> rd_valid && rd_data == $past(scratch_q)) // [R1]
    else $error("scratch read data wrong");

  a_restart_clear: assert property (key_write |=> all_cleared) // [R2]
    else $error("key write did not clear registers");

  a_bad_key_keep: assert property (
    cmd_valid && cmd_code == `WR_RESTART && cmd_wdata != `RESTART_KEY
    |=> !restart_q && $stable(scratch_q) && $stable(iso_size_q)
      && $stable(ack_size_q)) // [R12]
    else $error("non-key restart write changed state");

  a_iso_write: assert property (
    cmd_valid && cmd_code == `WR_ISO_SIZE
    |=> iso_size_q == $past(cmd_wdata)) // [R4]
    else $error("iso size write lost");

  a_ack_write: assert property (
    cmd_valid && cmd_code == `WR_ACK_SIZE
    |=> ack_size_q == $past(cmd_wdata)) // [R6]
    else $error("ack size write lost");

  a_status_read: assert property (
    cmd_valid && cmd_code == `RD_FILL_STATE
    |=> rd_data[15:6] == 10'h000 && rd_data[5:0] == $past(status)) // [R7]
    else $error("status read wrong");

  a_done_set: assert property (
    host_consumed[2] && !soft_clr && !eot_fill[2]
    |=> done_q[2] && !full_q[2]) // [R8]
    else $error("ack consumed flag not set");

  a_iso_done: assert property (
    host_consumed[1:0] == 2'h3 && !soft_clr
    |=> done_q[1:0] == 2'h3) // [R9]
    else $error("iso consumed flags not set");

  a_full_set: assert property (
    transfer_finished_event && eot_write && !soft_clr |=> (full_q & area_onehot(
      $past(eot_area))) != 3'h0) // [R10]
    else $error("full flag not set on fill end");

  a_status_nowrite: assert property (
    cmd_valid && cmd_code == `WR_FILL_STATE && !transfer_finished_event
    && host_consumed == 3'h0 |=> $stable(status)) // [R13]
    else $error("status word changed by write");

  // read-back end only clears done; a consume pulse in the same cycle wins
  sequence readback_end;
    transfer_finished_event && !eot_write && !soft_clr && host_consumed == 3'h0;
  endsequence

  a_back_clear: assert property (
    readback_end
    |=> (done_q & area_onehot($past(eot_area))) == 3'h0) // [R11]
    else $error("read-back end left done flag set");

  a_scratch_write: assert property (
    cmd_valid && cmd_code == `WR_SCRATCH
    |=> scratch_q == $past(cmd_wdata)) // [R1]
    else $error("scratch write lost");

  a_iso_read: assert property (
    cmd_valid && cmd_code == `RD_ISO_SIZE
    |=> rd_valid && rd_data == $past(iso_size_q)) // [R4]
    else $error("iso size read data wrong");

  a_ack_read: assert property (
    cmd_valid && cmd_code == `RD_ACK_SIZE
    |=> rd_valid && rd_data == $past(ack_size_q)) // [R6]
    else $error("ack size read data wrong");

  a_restart_cause: assert property (
    restart_q |-> $past(cmd_valid && cmd_code == `WR_RESTART
      && cmd_wdata == `RESTART_KEY)) // [R3] [R12]
    else $error("restart pulse without key write");

endmodule : buf_ctrl_regs
`default_nettype wire

// ### bench/test_usb_host_buffer_ctrl_regs.sv
`include "buf_ctrl_regs.svh"
`default_nettype none
module test_usb_host_buffer_ctrl_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import buf_ctrl_pkg::*;

  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic cmd_valid = 1'b0;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_wdata = 16'h0000;
  logic xfer_start = 1'b0;
  logic [15:0] xfer_count = 16'h0000;
  area_t xfer_area = first_iso_area;
  logic xfer_write = 1'b0;
  logic word_strobe = 1'b0;
  logic [2:0] host_consumed = 3'h0;
  logic [15:0] rd_data;
  logic rd_valid;
  logic [15:0] iso_size_q;
  logic [15:0] ack_size_q;
  logic restart_q;
  int mismatches = 0;
  int check_count = 0;
  int i;
  int a;
  int c;
  int n;
  int s;
  // bench model of the register state
  logic [15:0] m_scratch = 16'h0000;
  logic [15:0] m_iso = 16'h0000;
  logic [15:0] m_ack = 16'h0000;
  logic [2:0] m_full = 3'h0;
  logic [2:0] m_done = 3'h0;
  logic [7:0] rcodes [5] = '{`RD_SCRATCH, `RD_ISO_SIZE, `RD_ACK_SIZE,
                             `RD_FILL_STATE, 8'h30};

  always #2.5 ref_clk = ~ref_clk;

  buf_ctrl_regs buf_ctrl_regs_inst (
    .ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .xfer_start(xfer_start),
    .xfer_count(xfer_count), .xfer_area(xfer_area),
    .xfer_write(xfer_write), .word_strobe(word_strobe),
    .host_consumed(host_consumed), .rd_data(rd_data), .rd_valid(rd_valid),
    .iso_size_q(iso_size_q), .ack_size_q(ack_size_q),
    .restart_q(restart_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic tally_and_finish();
    if (mismatches == 0 && check_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [7:0] code, input logic [15:0] data);
    logic key;
    key = (code == `WR_RESTART) && (data == `RESTART_KEY);
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    cmd_wdata = data;
    case (code)
      `WR_SCRATCH: m_scratch = data;
      `WR_ISO_SIZE: m_iso = data;
      `WR_ACK_SIZE: m_ack = data;
      default: ;
    endcase
    if (key) begin
      // restart clears everything the host side holds
      {m_scratch, m_iso, m_ack, m_full, m_done} = '0;
    end
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    chk("restart pulse", {15'h0, restart_q}, {15'h0, key});
    chk("read strobe", {15'h0, rd_valid}, 16'h0000);
    chk("iso size out", iso_size_q, m_iso);
    chk("ack size out", ack_size_q, m_ack);
  endtask : wr

  task automatic rd(input logic [7:0] code);
    logic [15:0] exp;
    case (code)
      `RD_SCRATCH: exp = m_scratch;
      `RD_ISO_SIZE: exp = m_iso;
      `RD_ACK_SIZE: exp = m_ack;
      `RD_FILL_STATE: exp = {10'h000, m_done, m_full};
      default: exp = 16'h0000;
    endcase
    @(negedge ref_clk);
    cmd_valid = 1'b1;
    cmd_code = code;
    @(negedge ref_clk);
    cmd_valid = 1'b0;
    chk("read strobe", {15'h0, rd_valid}, 16'h0001);
    chk("read data", rd_data, exp);
  endtask : rd

  task automatic rd_all();
    for (int k = 0; k < 5; k++) begin
      rd(rcodes[k]);
    end
  endtask : rd_all

  task automatic strobe(input int cnt);
    @(negedge ref_clk);
    word_strobe = 1'b1;
    repeat (cnt) @(negedge ref_clk);
    word_strobe = 1'b0;
    // status lands two edges after the last word
    repeat (2) @(negedge ref_clk);
  endtask : strobe

  task automatic start(input int ar, input logic w, input logic [15:0] cnt);
    @(negedge ref_clk);
    xfer_start = 1'b1;
    xfer_area = area_t'(ar);
    xfer_write = w;
    xfer_count = cnt;
    @(negedge ref_clk);
    xfer_start = 1'b0;
  endtask : start

  task automatic consume(input logic [2:0] m);
    @(negedge ref_clk);
    host_consumed = m;
    @(negedge ref_clk);
    host_consumed = 3'h0;
    m_done = m_done | m;
    m_full = m_full & ~m;
  endtask : consume

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'hd055_d033));
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    nrst = 1'b1;
    rd_all();
    for (i = 0; i < 8; i++) begin
      wr(`WR_SCRATCH, 16'($urandom()));
      s = $urandom_range(0, `BUF_RAM_BYTES / 2);
      c = $urandom_range(0, `BUF_RAM_BYTES - 2 * s);
      wr(`WR_ISO_SIZE, 16'(s));
      wr(`WR_ACK_SIZE, 16'(c));
      wr(8'h80, 16'($urandom()));
      rd_all();
    end
    // fill each area, stopping one word short first when it takes more than one word
    for (a = 0; a < 3; a++) begin
      c = $urandom_range(0, 12);
      n = (c <= 1) ? 1 : (c + 1) / 2;
      start(a, 1'b1, 16'(c));
      if (n > 1) begin
        strobe(n - 1);
        rd(`RD_FILL_STATE);
      end
      strobe(1);
      m_full[a] = 1'b1;
      m_done[a] = 1'b0;
      rd(`RD_FILL_STATE);
    end
    consume(3'h1);
    consume(3'h2);
    rd(`RD_FILL_STATE);
    wr(`WR_FILL_STATE, 16'hffff);
    rd(`RD_FILL_STATE);
    wr(`WR_RESTART, 16'h01f6);
    wr(`WR_RESTART, 16'($urandom()) | 16'h0100);
    rd_all();
    start(0, 1'b0, 16'h0004);
    strobe(2);
    m_done[0] = 1'b0;
    rd(`RD_FILL_STATE);
    consume(3'h4);
    rd(`RD_FILL_STATE);
    consume(3'h3);
    rd(`RD_FILL_STATE);
    wr(`WR_RESTART, `RESTART_KEY);
    rd_all();
    tally_and_finish();
  end
endmodule : test_usb_host_buffer_ctrl_regs
`default_nettype wire
